// ==== shared/dcp_cfg.svh ====
// Purpose: Constants shared by both ends of the two-wire pot link.
// Assumes: Link clock period 32 ns at the device end, system clock 40 MHz at the master end.
// Notes: Definitions only.
`ifndef DCP_CFG_SVH
`define DCP_CFG_SVH

// Device type code, arbitrary value
`define DEV_TYPE_CODE 4'h5

// Slave address byte fields
`define SA_TYPE_MSB 7
`define SA_TYPE_LSB 4
`define SA_TGT_MSB 3
`define SA_TGT_LSB 1
`define SA_DIR 0

// Internal target codes
`define TGT_EEPROM 3'h0
`define TGT_CTRL 3'h2
`define TGT_POT 3'h7

// Instruction byte fields
`define INS_WT 7
`define INS_SEL_MSB 1
`define INS_SEL_LSB 0
`define POT_RESERVED 2'h3

// Control/status byte: write permit latch position
`define WPL_BIT 1
`define WPL_MASK 8'h02
`define EE_FILL 8'hff

// Pot sizes, highest data values and values before recall
`define POT0_TAPS 64
`define POT1_TAPS 100
`define POT2_TAPS 256
`define TAPS_ALL 420
`define POT0_MAX 8'h3f
`define POT1_MAX 8'h63
`define POT2_MAX 8'hff
`define POT0_INIT 8'h3f
`define POT1_INIT 8'h00
`define POT2_INIT 8'hff
`define STORE_INIT 8'h00

// Timing
`define LINK_PERIOD_NS 32
`define WRITE_CYCLE_MS 5
`define WRITE_CYCLES ((`WRITE_CYCLE_MS * 1000000) / `LINK_PERIOD_NS)
`define PURST_US 100
`define PURST_CYCLES ((`PURST_US * 1000 + `LINK_PERIOD_NS - 1) / `LINK_PERIOD_NS)
`define SYS_CLK_MHZ 40
`define SCL_KHZ 100
`define SCL_QTR_CYCLES ((`SYS_CLK_MHZ * 1000) / (4 * `SCL_KHZ))

`endif

// ==== shared/dcp_pkg.sv ====
// Purpose: Types for the two-wire pot link.
// Assumes: Nothing.
// Notes: Constants live in dcp_cfg.svh.
package dcp_pkg;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000,
    D_RX   = 3'b001,
    D_ACK  = 3'b010,
    D_TX   = 3'b011,
    D_MACK = 3'b100
  } dev_state_e;

  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_START = 2'b01,
    M_BIT   = 2'b10,
    M_STOP  = 2'b11
  } mst_state_e;

  typedef enum logic [1:0] {
    CMD_POT_WRITE = 2'b00,
    CMD_POT_READ  = 2'b01,
    CMD_REG_WRITE = 2'b10,
    CMD_POLL      = 2'b11
  } cmd_e;
endpackage

// ==== shared/two_wire_if.sv ====
// Purpose: Two-wire bus between the master and the pot device.
// Assumes: Open-drain data with pull-up; clock driven by the master only.
// Notes: Enables are active low; a driver pulls the line only with enable low and output low.
interface two_wire_if;
  logic scl;
  logic mSdaOut;
  logic mSdaOeN;
  logic dSdaOut;
  logic dSdaOeN;
  logic sda;

  assign sda = ((!mSdaOeN && !mSdaOut) || (!dSdaOeN && !dSdaOut)) ? 1'b0 : 1'b1;

  modport master (output scl, output mSdaOut, output mSdaOeN, input sda);
  modport device (input scl, input sda, output dSdaOut, output dSdaOeN);
endinterface

// ==== verilog/dcp_device.sv ====
// Purpose: Two-wire slave front end of a triple digital pot: address decode, busy polling, wiper registers.
// Assumes: Link clock runs free and far faster than the serial clock; arst_n is the power-up reset.
// Notes: EEPROM contents and control fields other than the write permit latch are not modelled.
// How it works
// [RULE_01] Upper address nibble must match device type
// [RULE_02] Address bits 3..1 pick EEPROM, control, pots
// [RULE_03] Address bit 0: one reads, zero writes
// [RULE_04] Master sends slave address first after START
// [RULE_05] Writes need the write permit latch set
// [RULE_06] Nonvolatile write plus STOP starts 5 ms cycle
// [RULE_07] During write cycle, address byte not acknowledged
// [RULE_08] Master polls with valid target, any direction
// [RULE_09] After cycle, poll acknowledged and transfer continues
// [RULE_10] One tap switch on per pot, decoded
// [RULE_11] Power-up loads wipers from nonvolatile store
// [RULE_12] Before recall wipers hold 63, 0, 255
// [RULE_13] New tap switch on before old off
// [RULE_14] Recall after supply good for reset time
// [RULE_15] Nonvolatile write updates wiper and store together
// [RULE_16] Volatile write updates wiper only
// [RULE_17] Pot write: address, instruction, data bytes
// [RULE_18] Pot read: random read returns wiper value
// [RULE_19] Instruction byte decoded only for pot target
// [RULE_20] Write type bit: zero volatile, one nonvolatile
// [RULE_21] Type in instruction MSB, pot in two LSBs
// [RULE_22] Pot select 11 not acknowledged
// [RULE_23] Data above maximum clamps to top tap
// [RULE_24] Unknown target code not acknowledged, transfer ignored
`include "dcp_cfg.svh"

module dcp_device #(
  parameter logic [3:0] DEV_TYPE = `DEV_TYPE_CODE,
  parameter int WRITE_CYCLES = `WRITE_CYCLES,
  parameter int PURST_CYCLES = `PURST_CYCLES
) (
  input wire logic linkClk,
  input wire logic arst_n,
  two_wire_if.device bus,
  input wire logic supplyOk,
  output wire logic [`TAPS_ALL-1:0] tapOn,
  output wire logic [23:0] wiperPos,
  output wire logic writeBusy
);
  localparam int BW = $clog2(WRITE_CYCLES + 1);
  localparam int PW = $clog2(PURST_CYCLES + 1);
  localparam logic [7:0] INIT [3] = '{`POT0_INIT, `POT1_INIT, `POT2_INIT};

  // Pin synchronisers: a change counts once the second and third stages agree
  logic [2:0] sclPipe_reg;
  logic [2:0] sdaPipe_reg;
  logic [2:0] supPipe_reg;
  logic sclS_reg;
  logic sdaS_reg;
  logic supS_reg;

  dcp_pkg::dev_state_e state_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [1:0] byteIdx_reg;
  logic [2:0] target_reg;
  logic rd_reg;
  logic [1:0] ptr_reg;
  logic wt_reg;
  logic ackGive_reg;
  logic oeN_reg;
  logic nvPend_reg;
  logic latch_reg;
  logic [BW-1:0] busyCnt_reg;
  logic [PW-1:0] recallCnt_reg;
  logic recalled_reg;
  logic [7:0] wiper_reg [3];
  logic [7:0] store_reg [3];

  wire sclNew = (sclPipe_reg[2] == sclPipe_reg[1]) ? sclPipe_reg[2] : sclS_reg;
  wire sdaNew = (sdaPipe_reg[2] == sdaPipe_reg[1]) ? sdaPipe_reg[2] : sdaS_reg;
  wire supNew = (supPipe_reg[2] == supPipe_reg[1]) ? supPipe_reg[2] : supS_reg;
  wire sclRise = sclNew & ~sclS_reg;
  wire sclFall = ~sclNew & sclS_reg;
  wire startSeen = sclS_reg & sclNew & sdaS_reg & ~sdaNew;
  wire stopSeen = sclS_reg & sclNew & ~sdaS_reg & sdaNew;

  wire busy = busyCnt_reg != '0;
  wire [7:0] rxByte = {shift_reg[6:0], sdaNew};
  wire [2:0] rxTgt = rxByte[`SA_TGT_MSB:`SA_TGT_LSB];
  wire typeOk = rxByte[`SA_TYPE_MSB:`SA_TYPE_LSB] == DEV_TYPE; // [RULE_01]
  wire tgtValid = (rxTgt == `TGT_EEPROM) || (rxTgt == `TGT_CTRL) || (rxTgt == `TGT_POT); // [RULE_02] [RULE_24]
  wire addrAck = typeOk & tgtValid & ~busy; // [RULE_07] [RULE_08] [RULE_09]
  wire isPot = target_reg == `TGT_POT;
  wire isCtrl = target_reg == `TGT_CTRL;
  wire instrByte = byteIdx_reg == 2'h1;
  wire dataByte = byteIdx_reg == 2'h2;
  wire selOk = rxByte[`INS_SEL_MSB:`INS_SEL_LSB] != `POT_RESERVED; // [RULE_22]
  wire byteAck = (byteIdx_reg == 2'h0) ? addrAck : !(isPot && instrByte && !selOk);
  wire byteDone = (state_reg == dcp_pkg::D_RX) && sclRise && (bitCnt_reg == 4'h7);

  wire [7:0] potMax = (ptr_reg == 2'h0) ? `POT0_MAX : (ptr_reg == 2'h1) ? `POT1_MAX : `POT2_MAX;
  wire [7:0] clamped = (rxByte > potMax) ? potMax : rxByte; // [RULE_23]
  wire potWrite = byteDone & isPot & dataByte & ~rd_reg & latch_reg & recalled_reg; // [RULE_05] [RULE_17]
  wire eeWrite = byteDone & (target_reg == `TGT_EEPROM) & dataByte & ~rd_reg & latch_reg; // [RULE_05]
  wire ctrlWrite = byteDone & isCtrl & instrByte & ~rd_reg;
  wire ctrlNv = ctrlWrite & ((rxByte & ~`WPL_MASK) != 8'h00);
  wire [7:0] ctrlByte = latch_reg ? `WPL_MASK : 8'h00;
  wire [7:0] txByte = isPot ? wiper_reg[ptr_reg] : isCtrl ? ctrlByte : `EE_FILL; // [RULE_18]

  assign bus.dSdaOut = 1'b0;
  assign bus.dSdaOeN = oeN_reg;
  assign writeBusy = busy;

  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      sclPipe_reg <= 3'h7;
      sdaPipe_reg <= 3'h7;
      supPipe_reg <= 3'h0;
      sclS_reg <= 1'b1;
      sdaS_reg <= 1'b1;
      supS_reg <= 1'b0;
    end else begin
      sclPipe_reg <= {sclPipe_reg[1:0], bus.scl};
      sdaPipe_reg <= {sdaPipe_reg[1:0], bus.sda};
      supPipe_reg <= {supPipe_reg[1:0], supplyOk};
      sclS_reg <= sclNew;
      sdaS_reg <= sdaNew;
      supS_reg <= supNew;
    end
  end

  // Byte engine: bits taken on serial clock rise, driven after its fall
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= dcp_pkg::D_IDLE;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      byteIdx_reg <= 2'h0;
      target_reg <= `TGT_EEPROM;
      rd_reg <= 1'b0;
      ptr_reg <= 2'h0;
      wt_reg <= 1'b0;
      ackGive_reg <= 1'b0;
      oeN_reg <= 1'b1;
      nvPend_reg <= 1'b0;
      latch_reg <= 1'b0;
    end else if (startSeen) begin
      // A repeated START drops any pending nonvolatile write
      state_reg <= dcp_pkg::D_RX;
      bitCnt_reg <= 4'h0;
      byteIdx_reg <= 2'h0;
      oeN_reg <= 1'b1;
      nvPend_reg <= 1'b0;
    end else if (stopSeen) begin
      state_reg <= dcp_pkg::D_IDLE;
      oeN_reg <= 1'b1;
      nvPend_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        dcp_pkg::D_IDLE: begin
          oeN_reg <= 1'b1;
        end
        dcp_pkg::D_RX: begin
          if (sclRise && bitCnt_reg != 4'h8) begin
            shift_reg <= rxByte;
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
          if (byteDone) begin
            ackGive_reg <= byteAck;
            if (byteIdx_reg == 2'h0) begin
              target_reg <= rxTgt; // [RULE_02]
              rd_reg <= rxByte[`SA_DIR]; // [RULE_03]
            end
            if (isPot && instrByte && selOk) begin // [RULE_19]
              ptr_reg <= rxByte[`INS_SEL_MSB:`INS_SEL_LSB]; // [RULE_21]
              wt_reg <= rxByte[`INS_WT]; // [RULE_20] [RULE_21]
            end
            if (ctrlWrite) begin
              latch_reg <= rxByte[`WPL_BIT];
            end
            if ((potWrite && wt_reg) || eeWrite || ctrlNv) begin
              nvPend_reg <= 1'b1;
            end
          end else if (sclFall && bitCnt_reg == 4'h8) begin
            if (ackGive_reg) begin
              oeN_reg <= 1'b0;
              state_reg <= dcp_pkg::D_ACK;
            end else begin
              state_reg <= dcp_pkg::D_IDLE; // [RULE_24] [RULE_22] [RULE_07]
            end
          end
        end
        dcp_pkg::D_ACK: begin
          if (sclFall) begin
            byteIdx_reg <= (byteIdx_reg == 2'h3) ? 2'h3 : byteIdx_reg + 2'h1;
            if (rd_reg) begin
              shift_reg <= {txByte[6:0], 1'b0};
              oeN_reg <= txByte[7];
              bitCnt_reg <= 4'h1;
              state_reg <= dcp_pkg::D_TX;
            end else begin
              oeN_reg <= 1'b1;
              bitCnt_reg <= 4'h0;
              state_reg <= dcp_pkg::D_RX;
            end
          end
        end
        dcp_pkg::D_TX: begin
          if (sclFall) begin
            if (bitCnt_reg == 4'h8) begin
              oeN_reg <= 1'b1;
              state_reg <= dcp_pkg::D_MACK;
            end else begin
              oeN_reg <= shift_reg[7];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bitCnt_reg <= bitCnt_reg + 4'h1;
            end
          end
        end
        dcp_pkg::D_MACK: begin
          // Master acknowledge repeats the byte; no acknowledge ends sending
          if (sclRise && sdaNew) begin
            state_reg <= dcp_pkg::D_IDLE;
          end else if (sclFall) begin
            shift_reg <= {txByte[6:0], 1'b0};
            oeN_reg <= txByte[7];
            bitCnt_reg <= 4'h1;
            state_reg <= dcp_pkg::D_TX;
          end
        end
        default: begin
          state_reg <= dcp_pkg::D_IDLE;
        end
      endcase
    end
  end

  // Internal write cycle, started only by a STOP that closes a good sequence
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      busyCnt_reg <= '0;
    end else if (stopSeen && nvPend_reg) begin
      busyCnt_reg <= BW'(WRITE_CYCLES); // [RULE_06]
    end else if (busy) begin
      busyCnt_reg <= busyCnt_reg - BW'(1);
    end
  end

  // Store survives supply dips; only arst_n returns it to factory value
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n) begin
      recallCnt_reg <= '0;
      recalled_reg <= 1'b0;
      wiper_reg[0] <= INIT[0];
      wiper_reg[1] <= INIT[1];
      wiper_reg[2] <= INIT[2];
      store_reg[0] <= `STORE_INIT;
      store_reg[1] <= `STORE_INIT;
      store_reg[2] <= `STORE_INIT;
    end else if (!supS_reg) begin
      recallCnt_reg <= '0;
      recalled_reg <= 1'b0;
      wiper_reg <= INIT; // [RULE_12]
    end else if (!recalled_reg) begin
      if (recallCnt_reg == PW'(PURST_CYCLES)) begin
        recalled_reg <= 1'b1;
        wiper_reg <= store_reg; // [RULE_11] [RULE_14]
      end else begin
        recallCnt_reg <= recallCnt_reg + PW'(1);
      end
    end else if (potWrite) begin
      wiper_reg[ptr_reg] <= clamped; // [RULE_16]
      if (wt_reg) begin
        store_reg[ptr_reg] <= clamped; // [RULE_15]
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : pot
      localparam int N = (g == 0) ? `POT0_TAPS : (g == 1) ? `POT1_TAPS : `POT2_TAPS;
      localparam int BASE = (g == 0) ? 0 : (g == 1) ? `POT0_TAPS : `POT0_TAPS + `POT1_TAPS;
      localparam logic [N-1:0] ONE = N'(1);
      logic [7:0] prev_reg;
      logic [N-1:0] on_reg;

      // Old and new tap overlap for one cycle so the wiper never floats
      always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
          prev_reg <= INIT[g];
          on_reg <= '0;
        end else begin
          prev_reg <= wiper_reg[g];
          on_reg <= (ONE << wiper_reg[g]) | (ONE << prev_reg); // [RULE_10] [RULE_13]
        end
      end

      assign tapOn[BASE +: N] = on_reg;
      assign wiperPos[8*g +: 8] = wiper_reg[g];
    end
  endgenerate
endmodule

// ==== verilog/dcp_master.sv ====
// Purpose: Two-wire bus master that drives pot writes, pot reads, control writes and busy polls.
// Assumes: Single master; no clock stretching by the device.
// Notes: Serial clock is a divider of sys_clk, four quarter periods per bit.
`include "dcp_cfg.svh"

module dcp_master #(
  parameter int QTR_CYCLES = `SCL_QTR_CYCLES,
  parameter logic [3:0] DEV_TYPE = `DEV_TYPE_CODE
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  two_wire_if.master bus,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire dcp_pkg::cmd_e cmdKind,
  input wire logic [2:0] cmdTarget,
  input wire logic cmdRead,
  input wire logic [7:0] cmdInstr,
  input wire logic [7:0] cmdData,
  output logic doneValid,
  output logic doneAck,
  output logic [7:0] doneData
);
  localparam int QW = $clog2(QTR_CYCLES + 1);

  dcp_pkg::mst_state_e state_reg;
  dcp_pkg::cmd_e kind_reg;
  logic [2:0] tgt_reg;
  logic rdSel_reg;
  logic [7:0] instr_reg;
  logic [7:0] data_reg;
  logic [QW-1:0] qCnt_reg;
  logic [1:0] phase_reg;
  logic [3:0] bitIdx_reg;
  logic [2:0] step_reg;
  logic [7:0] sh_reg;
  logic sclOut_reg;
  logic oeN_reg;
  logic ackAll_reg;
  logic [2:0] sdaPipe_reg;
  logic sdaS_reg;

  wire sdaNew = (sdaPipe_reg[2] == sdaPipe_reg[1]) ? sdaPipe_reg[2] : sdaS_reg;
  wire tick = qCnt_reg == QW'(QTR_CYCLES - 1);
  wire isRdCmd = kind_reg == dcp_pkg::CMD_POT_READ;
  wire isPoll = kind_reg == dcp_pkg::CMD_POLL;
  // An acknowledged read poll clocks one byte out so the device lets go of the line before STOP
  wire [2:0] lastStep = (kind_reg == dcp_pkg::CMD_POT_WRITE) ? 3'h2 :
                        isRdCmd ? 3'h3 :
                        (kind_reg == dcp_pkg::CMD_REG_WRITE) ? 3'h1 : {2'h0, rdSel_reg};
  wire rsStep = isRdCmd && (step_reg == 3'h2);
  wire readStep = (isRdCmd && (step_reg == 3'h3)) || (isPoll && (step_reg == 3'h1));
  // Polls take the caller's direction; a random read switches to read on the repeated address
  wire addrDir = (kind_reg == dcp_pkg::CMD_POLL) ? rdSel_reg : rsStep; // [RULE_03] [RULE_08] [RULE_18]
  wire [7:0] addrByte = {DEV_TYPE, tgt_reg, addrDir}; // [RULE_01]
  wire useInstr = (step_reg == 3'h1) && (kind_reg != dcp_pkg::CMD_REG_WRITE);
  wire [7:0] curByte = ((step_reg == 3'h0) || rsStep) ? addrByte : useInstr ? instr_reg : data_reg; // [RULE_04] [RULE_17]
  wire bitVal = (bitIdx_reg == 4'h0) ? curByte[7] : sh_reg[7];

  assign cmdReady = state_reg == dcp_pkg::M_IDLE;
  assign bus.scl = sclOut_reg;
  assign bus.mSdaOut = 1'b0;
  assign bus.mSdaOeN = oeN_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sdaPipe_reg <= 3'h7;
      sdaS_reg <= 1'b1;
    end else begin
      sdaPipe_reg <= {sdaPipe_reg[1:0], bus.sda};
      sdaS_reg <= sdaNew;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      qCnt_reg <= '0;
    end else if (state_reg == dcp_pkg::M_IDLE || tick) begin
      qCnt_reg <= '0;
    end else begin
      qCnt_reg <= qCnt_reg + QW'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= dcp_pkg::M_IDLE;
      kind_reg <= dcp_pkg::CMD_POLL;
      tgt_reg <= 3'h0;
      rdSel_reg <= 1'b0;
      instr_reg <= 8'h00;
      data_reg <= 8'h00;
      phase_reg <= 2'h0;
      bitIdx_reg <= 4'h0;
      step_reg <= 3'h0;
      sh_reg <= 8'h00;
      sclOut_reg <= 1'b1;
      oeN_reg <= 1'b1;
      ackAll_reg <= 1'b0;
      doneValid <= 1'b0;
      doneAck <= 1'b0;
      doneData <= 8'h00;
    end else begin
      doneValid <= 1'b0;
      if (state_reg == dcp_pkg::M_IDLE) begin
        if (cmdValid) begin
          kind_reg <= cmdKind;
          tgt_reg <= cmdTarget;
          rdSel_reg <= cmdRead;
          instr_reg <= cmdInstr;
          data_reg <= cmdData;
          step_reg <= 3'h0;
          phase_reg <= 2'h0;
          ackAll_reg <= 1'b1;
          state_reg <= dcp_pkg::M_START;
        end
      end else if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        unique case (state_reg)
          dcp_pkg::M_START: begin
            unique case (phase_reg)
              2'h0: oeN_reg <= 1'b1;
              2'h1: sclOut_reg <= 1'b1;
              2'h2: oeN_reg <= 1'b0;
              2'h3: begin
                sclOut_reg <= 1'b0;
                bitIdx_reg <= 4'h0;
                state_reg <= dcp_pkg::M_BIT;
              end
            endcase
          end
          dcp_pkg::M_BIT: begin
            unique case (phase_reg)
              2'h0: begin
                if (bitIdx_reg == 4'h0) begin
                  sh_reg <= curByte;
                end
                // Read bytes and the acknowledge slot release the line; one byte read ends with no acknowledge
                oeN_reg <= (bitIdx_reg != 4'h8 && !readStep) ? bitVal : 1'b1;
              end
              2'h1: sclOut_reg <= 1'b1;
              2'h2: begin
                if (bitIdx_reg != 4'h8) begin
                  sh_reg <= {sh_reg[6:0], sdaNew};
                end else if (!readStep && sdaNew) begin
                  ackAll_reg <= 1'b0; // [RULE_07]
                end
              end
              2'h3: begin
                sclOut_reg <= 1'b0;
                if (bitIdx_reg != 4'h8) begin
                  bitIdx_reg <= bitIdx_reg + 4'h1;
                end else begin
                  bitIdx_reg <= 4'h0;
                  if (readStep && isRdCmd) begin
                    doneData <= sh_reg;
                  end
                  if (!ackAll_reg || step_reg == lastStep) begin
                    state_reg <= dcp_pkg::M_STOP;
                  end else begin
                    step_reg <= step_reg + 3'h1;
                    if (isRdCmd && step_reg == 3'h1) begin
                      state_reg <= dcp_pkg::M_START; // [RULE_18]
                    end
                  end
                end
              end
            endcase
          end
          dcp_pkg::M_STOP: begin
            unique case (phase_reg)
              2'h0: oeN_reg <= 1'b0;
              2'h1: sclOut_reg <= 1'b1;
              2'h2: oeN_reg <= 1'b1;
              2'h3: begin
                doneValid <= 1'b1;
                doneAck <= ackAll_reg; // [RULE_09]
                state_reg <= dcp_pkg::M_IDLE;
              end
            endcase
          end
          dcp_pkg::M_IDLE: begin
            oeN_reg <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ==== bench/dcp_link_checker.sv ====
// Purpose: Wire and wiper checks beside the two-wire pot link
// Assumes: Link clock domain only; device outputs wired in by the bench
// Notes: Busy length allows two cycles of slack for the STOP sync
`include "dcp_cfg.svh"
module dcp_link_checker #(
  parameter int WRITE_CYCLES = 200
) (
  input wire logic linkClk,
  input wire logic arst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic dSdaOeN,
  input wire logic supplyOk,
  input wire logic writeBusy,
  input wire logic [23:0] wiperPos,
  input wire logic [`TAPS_ALL-1:0] tapOn
);
  logic [15:0] busyCnt_reg;
  always_ff @(posedge linkClk or negedge arst_n) begin
    if (!arst_n)
      busyCnt_reg <= 16'h0000;
    else
      busyCnt_reg <= writeBusy ? busyCnt_reg + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (!arst_n);
  busy_quiet_a: assert property (writeBusy |-> dSdaOeN)
    else $error("device drove sda while busy");
  busy_len_a: assert property ($fell(writeBusy) |-> busyCnt_reg inside {[WRITE_CYCLES-2:WRITE_CYCLES+2]})
    else $error("write cycle length wrong");
  stop_start_a: assert property ($rose(writeBusy) |-> scl && sda)
    else $error("write cycle began outside STOP");
  taps_live_a: assert property ($past(arst_n, 2) |-> $countones(tapOn[63:0]) inside {[1:2]} &&
    $countones(tapOn[163:64]) inside {[1:2]} && $countones(tapOn[419:164]) inside {[1:2]})
    else $error("tap switch count wrong");
  tap_match_a: assert property ($past(arst_n, 3) && wiperPos == $past(wiperPos) &&
    wiperPos == $past(wiperPos, 3) |-> tapOn[wiperPos[5:0]] && $countones(tapOn[63:0]) == 1)
    else $error("tap does not follow wiper");
  clamp_max_a: assert property (wiperPos[7:0] <= 8'h3f && wiperPos[15:8] <= 8'h63)
    else $error("wiper above top tap");
  init_hold_a: assert property (!supplyOk [*6] |-> wiperPos == 24'hff003f)
    else $error("wiper not at initial value");
  recall_wait_a: assert property ($rose(supplyOk) |-> (wiperPos == 24'hff003f) [*8])
    else $error("recall too early");
  sda_edge_a: assert property ($changed(dSdaOeN) |-> !scl)
    else $error("device moved sda with scl high");
  cover property ($rose(writeBusy));
  cover property ($fell(dSdaOeN));
  cover property ($changed(wiperPos));
endmodule

// ==== bench/slave_address_decode_wiper_ctrl_bench.sv ====
// Purpose: Master and pot device joined over the two-wire link
// Assumes: Shortened write cycle, recall time and bit timing
// Notes: Wiper expectations follow the command sequence
`include "dcp_cfg.svh"
module slave_address_decode_wiper_ctrl_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int WC = 2000;
  logic sys_clk = 1'b0;
  logic linkClk = 1'b0;
  logic arst_n = 1'b0;
  logic supplyOk = 1'b0;
  logic cmdValid = 1'b0;
  dcp_pkg::cmd_e cmdKind = dcp_pkg::CMD_POLL;
  logic [2:0] cmdTarget = 3'h0;
  logic cmdRead = 1'b0;
  logic [7:0] cmdInstr = 8'h00;
  logic [7:0] cmdData = 8'h00;
  logic cmdReady, doneValid, doneAck, writeBusy;
  logic [7:0] doneData;
  logic [23:0] wiperPos;
  logic [`TAPS_ALL-1:0] tapOn;
  int fail_count = 0;
  int checked = 0;
  two_wire_if link();
  dcp_master #(.QTR_CYCLES(8)) i_dcp_master (.sys_clk(sys_clk), .arst_n(arst_n), .bus(link),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdTarget(cmdTarget), .cmdRead(cmdRead),
    .cmdInstr(cmdInstr), .cmdData(cmdData), .doneValid(doneValid), .doneAck(doneAck), .doneData(doneData));
  dcp_device #(.WRITE_CYCLES(WC), .PURST_CYCLES(20)) i_dcp_device (.linkClk(linkClk), .arst_n(arst_n),
    .bus(link), .supplyOk(supplyOk), .tapOn(tapOn), .wiperPos(wiperPos), .writeBusy(writeBusy));
  dcp_link_checker #(.WRITE_CYCLES(WC)) i_dcp_link_checker (.linkClk(linkClk), .arst_n(arst_n),
    .scl(link.scl), .sda(link.sda), .dSdaOeN(link.dSdaOeN), .supplyOk(supplyOk), .writeBusy(writeBusy),
    .wiperPos(wiperPos), .tapOn(tapOn));
  initial forever #12.5 sys_clk = ~sys_clk;
  // Odd offset keeps the link clock out of phase with sys_clk
  initial begin
    #7;
    forever #16 linkClk = ~linkClk;
  end
  task automatic finish_test();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  task automatic cmd(input dcp_pkg::cmd_e k, input logic [2:0] t, input logic r, input logic [7:0] i,
    input logic [7:0] d);
    int n;
    @(negedge sys_clk);
    cmdKind = k;
    cmdTarget = t;
    cmdRead = r;
    cmdInstr = i;
    cmdData = d;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(negedge sys_clk);
    @(negedge sys_clk);
    cmdValid = 1'b0;
    n = 0;
    while (doneValid !== 1'b1 && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 3000, "no completion");
    // Let the STOP reach the device before looking at busy
    repeat (8) @(negedge sys_clk);
  endtask
  initial begin
    int n;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    chk(wiperPos === 24'hff003f, "initial wipers");
    supplyOk = 1'b1;
    repeat (60) @(negedge sys_clk);
    chk(wiperPos === 24'h000000, "recall");
    cmd(dcp_pkg::CMD_POT_WRITE, 3'h7, 1'b0, 8'h01, 8'h20);
    chk(doneAck === 1'b1 && wiperPos === 24'h000000, "write without latch");
    cmd(dcp_pkg::CMD_REG_WRITE, 3'h2, 1'b0, 8'h00, 8'h02);
    chk(doneAck === 1'b1 && writeBusy === 1'b0, "latch write");
    cmd(dcp_pkg::CMD_POT_WRITE, 3'h7, 1'b0, 8'h01, 8'h20);
    chk(wiperPos === 24'h002000 && writeBusy === 1'b0, "volatile write");
    cmd(dcp_pkg::CMD_POT_WRITE, 3'h7, 1'b0, 8'h80, 8'h50);
    chk(wiperPos === 24'h00203f && writeBusy === 1'b1, "nonvolatile clamp");
    cmd(dcp_pkg::CMD_POLL, 3'h7, 1'b1, 8'h00, 8'h00);
    chk(doneAck === 1'b0, "busy poll");
    n = 0;
    while (writeBusy !== 1'b0 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(writeBusy === 1'b0, "busy stuck");
    for (int i = 0; i < 8; i++) begin
      cmd(dcp_pkg::CMD_POLL, i[2:0], i[0], 8'h00, 8'h00);
      chk(doneAck === (i == 0 || i == 2 || i == 7), "target decode");
    end
    cmd(dcp_pkg::CMD_POT_WRITE, 3'h7, 1'b0, 8'h03, 8'h11);
    chk(doneAck === 1'b0 && wiperPos === 24'h00203f, "reserved select");
    cmd(dcp_pkg::CMD_POT_READ, 3'h7, 1'b0, 8'h01, 8'h00);
    chk(doneAck === 1'b1 && doneData === 8'h20, "read pot1");
    cmd(dcp_pkg::CMD_POT_READ, 3'h7, 1'b0, 8'h80, 8'h00);
    chk(doneData === 8'h3f, "read pot0");
    // Array byte write: address, array offset, data; its STOP starts the write cycle
    cmd(dcp_pkg::CMD_POT_WRITE, 3'h0, 1'b0, 8'h10, 8'h55);
    chk(doneAck === 1'b1 && writeBusy === 1'b1, "array write busy");
    n = 0;
    do begin
      cmd(dcp_pkg::CMD_POLL, 3'h0, 1'b0, 8'h00, 8'h00);
      n++;
    end while (doneAck !== 1'b1 && n < 20);
    chk(doneAck === 1'b1 && writeBusy === 1'b0 && n > 1, "poll after write");
    supplyOk = 1'b0;
    repeat (20) @(negedge sys_clk);
    chk(wiperPos === 24'hff003f, "supply low");
    supplyOk = 1'b1;
    repeat (60) @(negedge sys_clk);
    chk(wiperPos === 24'h00003f, "recall after cycle");
    finish_test();
  end
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end
endmodule
